// >>> dsprt_pkg.sv
package dsprt_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam logic [7:0] ADDR_SCON = 8'h98;
	localparam logic [7:0] ADDR_SBUF = 8'h99;
	localparam logic [7:0] ADDR_RCTL = 8'hc8;
	localparam logic [7:0] ADDR_TMOD = 8'hc9;
	localparam logic [7:0] ADDR_RLO = 8'hca;
	localparam logic [7:0] ADDR_RHI = 8'hcb;
	localparam logic [7:0] ADDR_CLO = 8'hcc;
	localparam logic [7:0] ADDR_CHI = 8'hcd;
	localparam int SC_MODE_A = 7;
	localparam int SC_MODE_B = 6;
	localparam int SC_MPF = 5;
	localparam int SC_REN = 4;
	localparam int SC_TB8 = 3;
	localparam int SC_RB8 = 2;
	localparam int SC_TI = 1;
	localparam int SC_RI = 0;
	localparam int RC_RXSRC = 5;
	localparam int RC_TXSRC = 4;
	localparam int RC_RUN = 2;
	localparam int TM_SKEW = 2;
	localparam int TM_DIR = 0;
	localparam logic [7:0] SCON_RST = 8'h00;
	localparam logic [7:0] RCTL_RST = 8'h00;
	localparam logic TM_DIR_RST = 1'b0;
	localparam logic [15:0] RELOAD_RST = 16'h0000;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	localparam logic [2:0] MC_LAST = 3'h5;
	localparam logic [2:0] MC_HALF = 3'h3;
	localparam logic [3:0] OS_LAST = 4'hf;
	localparam logic [3:0] OS_MID = 4'h7;
	localparam logic [3:0] RX_SAMPLES_LAST = 4'h8;
	localparam logic [3:0] M0_BITS_LAST = 4'h7;
	localparam logic [3:0] M1_BITS_LAST = 4'h9;
	localparam logic [3:0] M23_BITS_LAST = 4'ha;
	localparam logic [3:0] M1_TI_BIT = 4'h8;
	localparam logic [3:0] M23_TI_BIT = 4'h9;
	localparam int DATA_W = 8;
	localparam int TX_FIFO_DEPTH = 16;
	typedef enum logic [1:0] {DSPRT_M0, DSPRT_M1, DSPRT_M2, DSPRT_M3} dsprt_mode_e;
	typedef enum logic {DSPRT_TX_IDLE, DSPRT_TX_SEND} dsprt_tx_e;
	typedef enum logic [1:0] {DSPRT_RX_IDLE, DSPRT_RX_START, DSPRT_RX_BITS, DSPRT_RX_DONE} dsprt_rx_e;
endpackage : dsprt_pkg

// >>> dsprt_fifo.sv
`timescale 1ns/1ps
module dsprt_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;
	assign in_ready = cnt_q != (AW+1)'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge ref_clk) begin
		if (push)
			mem_q[wr_q] <= in_data;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push)
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			if (pop)
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule : dsprt_fifo

// >>> dsprt_top.sv
`timescale 1ns/1ps
// What this block does
// - skew flag sets if high byte steps between low and high reads; clears after low read
// - direction bit set counts up, cleared counts down
// - low and high count bytes form one 16-bit counter
// - reload copies reload high and low bytes into count high and low bytes
// - one finished byte held while next arrives; unread first byte loses a byte
// - data buffer write feeds transmitter; read returns separate receive register
// - two mode bits choose among four modes
// - mode 0 shifts eight bits lsb first on rx pin, tx pin is clock
// - mode 0 bit rate is clock over six
// - mode 1 frame is start 0, eight data lsb first, stop 1
// - mode 1 reception stores stop bit in received ninth bit
// - mode 1 rate comes from auxiliary or reload timer overflows
// - modes 2 and 3 frame is start, eight data, ninth bit, stop
// - modes 2 and 3 send transmit ninth bit as ninth data bit
// - modes 2 and 3 store received ninth bit, stop bit ignored
// - mode 2 rate is clock over sixteen or over thirty-two
// - mode 3 equals mode 2 except rate from timer overflows
// - data buffer write queues a transmission in every mode; a write while the fifo is full is dropped
// - mode 0 reception starts when receive flag clear and enable set
// - async modes start reception on start bit while enable set
// - transmitter and receiver run independently at the same time in modes 1 to 3; mode 0 reception waits for transmission
// - transmit flag sets after eighth bit in modes 0,1, ninth in 2,3
// - receive flag sets one clock after stop or ninth bit sample
// - with filter on, ninth bit 0 loads nothing and raises no flag
// - source select bit 1 uses reload timer overflows, 0 the other timer
module dsprt_top (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	input wire logic aux_timer_ovf,
	input wire logic mode2_fast_rate,
	input wire logic uart_rx_in,
	output logic uart_rx_out,
	output logic uart_rx_oe,
	output logic uart_tx,
	output logic tx_buf_ready,
	output logic reload_timer_ovf
);
	import dsprt_pkg::*;

	logic [7:0] scon_q;
	logic [7:0] rctl_q;
	logic dir_q;
	logic skew_q;
	logic armed_q;
	logic rd_clo_q;
	logic [15:0] reload_q;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic [2:0] mc_q;
	logic ovf_q;
	logic m2_div_q;
	logic [7:0] rdata_q;
	logic [7:0] rx_buf_q;

	dsprt_mode_e mode;
	logic mc_tick;
	logic step;
	logic at_end;
	logic hi_step;
	logic m2_tick;
	logic wr_scon;
	logic wr_sbuf;
	logic wr_rctl;
	logic wr_tmod;
	logic wr_rlo;
	logic wr_rhi;
	logic wr_clo;
	logic wr_chi;
	logic rd_clo;
	logic rd_chi;
	logic ti_set;
	logic ri_set;
	logic rb8_load;
	logic rb8_val;

	assign mode = dsprt_mode_e'({scon_q[SC_MODE_A], scon_q[SC_MODE_B]});
	assign wr_scon = sfr_wr && sfr_addr == ADDR_SCON;
	assign wr_sbuf = sfr_wr && sfr_addr == ADDR_SBUF;
	assign wr_rctl = sfr_wr && sfr_addr == ADDR_RCTL;
	assign wr_tmod = sfr_wr && sfr_addr == ADDR_TMOD;
	assign wr_rlo = sfr_wr && sfr_addr == ADDR_RLO;
	assign wr_rhi = sfr_wr && sfr_addr == ADDR_RHI;
	assign wr_clo = sfr_wr && sfr_addr == ADDR_CLO;
	assign wr_chi = sfr_wr && sfr_addr == ADDR_CHI;
	assign rd_clo = sfr_rd && sfr_addr == ADDR_CLO;
	assign rd_chi = sfr_rd && sfr_addr == ADDR_CHI;

	// machine cycle of six clocks
	assign mc_tick = mc_q == MC_LAST;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			mc_q <= '0;
		else
			mc_q <= mc_tick ? 3'h0 : mc_q + 3'h1;
	end

	// reload timer, one step per machine cycle
	assign step = rctl_q[RC_RUN] && mc_q == 3'h0;
	assign at_end = dir_q ? (cnt_q == COUNT_MAX) : (cnt_q == COUNT_RST);
	always_comb begin
		if (at_end)
			cnt_d = reload_q;
		else if (dir_q)
			cnt_d = cnt_q + 16'h0001;
		else
			cnt_d = cnt_q - 16'h0001;
	end
	assign hi_step = step && !wr_chi && cnt_d[15:8] != cnt_q[15:8];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= COUNT_RST;
		end else begin
			if (wr_clo)
				cnt_q[7:0] <= sfr_wdata;
			else if (step)
				cnt_q[7:0] <= cnt_d[7:0];
			if (wr_chi)
				cnt_q[15:8] <= sfr_wdata;
			else if (step)
				cnt_q[15:8] <= cnt_d[15:8];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			ovf_q <= 1'b0;
		else
			ovf_q <= step && at_end;
	end
	assign reload_timer_ovf = ovf_q;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reload_q <= RELOAD_RST;
		end else begin
			if (wr_rlo)
				reload_q[7:0] <= sfr_wdata;
			if (wr_rhi)
				reload_q[15:8] <= sfr_wdata;
		end
	end

	// read skew tracking; set beats clear
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			armed_q <= 1'b0;
			rd_clo_q <= 1'b0;
			skew_q <= 1'b0;
		end else begin
			rd_clo_q <= rd_clo;
			if (rd_clo)
				armed_q <= 1'b1;
			else if (rd_chi)
				armed_q <= 1'b0;
			if (armed_q && hi_step)
				skew_q <= 1'b1;
			else if (rd_clo_q && !rd_clo)
				skew_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rctl_q <= RCTL_RST;
			dir_q <= TM_DIR_RST;
		end else begin
			if (wr_rctl)
				rctl_q <= sfr_wdata & ((8'h01 << RC_RXSRC) | (8'h01 << RC_TXSRC) | (8'h01 << RC_RUN));
			if (wr_tmod)
				dir_q <= sfr_wdata[TM_DIR];
		end
	end

	// mode 2 oversample: every clock or every second clock
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			m2_div_q <= 1'b0;
		else
			m2_div_q <= !m2_div_q;
	end
	assign m2_tick = mode2_fast_rate || m2_div_q;

	// transmit path: fifo then shifter
	logic fifo_valid;
	logic fifo_pop;
	logic [7:0] fifo_data;
	dsprt_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(TX_FIFO_DEPTH)
	) u_tx_fifo (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.in_valid(wr_sbuf),
		.in_ready(tx_buf_ready),
		.in_data(sfr_wdata),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	dsprt_tx_e tx_state_q;
	logic [10:0] tx_frame_q;
	logic [3:0] tx_bit_q;
	logic [3:0] tx_sub_q;
	logic tx_pin_q;
	logic tx_os_tick;
	logic tx_bit_end;
	logic [3:0] tx_last;
	logic [3:0] tx_ti_bit;
	logic tx_m0_busy;

	assign tx_os_tick = (mode == DSPRT_M2) ? m2_tick :
		(rctl_q[RC_TXSRC] ? ovf_q : aux_timer_ovf);
	assign tx_bit_end = (mode == DSPRT_M0) ? mc_tick : (tx_os_tick && tx_sub_q == OS_LAST);
	assign tx_last = (mode == DSPRT_M0) ? M0_BITS_LAST : (mode == DSPRT_M1) ? M1_BITS_LAST : M23_BITS_LAST;
	assign tx_ti_bit = (mode == DSPRT_M0) ? M0_BITS_LAST : (mode == DSPRT_M1) ? M1_TI_BIT : M23_TI_BIT;
	// frame starts on a bit boundary so mode 0 stays aligned to the machine cycle
	assign fifo_pop = tx_state_q == DSPRT_TX_IDLE && fifo_valid && (mode != DSPRT_M0 || mc_tick);
	assign tx_m0_busy = mode == DSPRT_M0 && tx_state_q == DSPRT_TX_SEND;
	assign ti_set = tx_state_q == DSPRT_TX_SEND && tx_bit_end && tx_bit_q == tx_ti_bit;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_state_q <= DSPRT_TX_IDLE;
			tx_frame_q <= '1;
			tx_bit_q <= '0;
			tx_sub_q <= '0;
		end else begin
			case (tx_state_q)
				DSPRT_TX_IDLE: begin
					if (fifo_pop) begin
						tx_state_q <= DSPRT_TX_SEND;
						tx_bit_q <= '0;
						tx_sub_q <= '0;
						case (mode)
							DSPRT_M0: tx_frame_q <= {3'b111, fifo_data};
							DSPRT_M1: tx_frame_q <= {2'b11, fifo_data, 1'b0};
							default: tx_frame_q <= {1'b1, scon_q[SC_TB8], fifo_data, 1'b0};
						endcase
					end
				end
				DSPRT_TX_SEND: begin
					if (tx_os_tick && mode != DSPRT_M0)
						tx_sub_q <= tx_sub_q + 4'h1;
					if (tx_bit_end) begin
						tx_frame_q <= {1'b1, tx_frame_q[10:1]};
						tx_bit_q <= tx_bit_q + 4'h1;
						if (tx_bit_q == tx_last)
							tx_state_q <= DSPRT_TX_IDLE;
					end
				end
				default: tx_state_q <= DSPRT_TX_IDLE;
			endcase
		end
	end

	// receiver
	dsprt_rx_e rx_state_q;
	logic [8:0] rx_shift_q;
	logic [3:0] rx_bit_q;
	logic [3:0] rx_sub_q;
	logic rx_prev_q;
	logic rx_os_tick;
	logic rx_accept;
	logic rx_m0_busy;

	assign rx_os_tick = (mode == DSPRT_M2) ? m2_tick :
		(rctl_q[RC_RXSRC] ? ovf_q : aux_timer_ovf);
	assign rx_m0_busy = mode == DSPRT_M0 && rx_state_q == DSPRT_RX_BITS;
	// the received bit that the filter looks at is the stop bit in mode 1, the ninth bit in modes 2 and 3
	assign rx_accept = !scon_q[SC_RI] && (mode == DSPRT_M0 || !scon_q[SC_MPF] || rx_shift_q[8]);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			rx_prev_q <= 1'b1;
		else
			rx_prev_q <= uart_rx_in;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_state_q <= DSPRT_RX_IDLE;
			rx_shift_q <= '0;
			rx_bit_q <= '0;
			rx_sub_q <= '0;
		end else begin
			case (rx_state_q)
				DSPRT_RX_IDLE: begin
					rx_bit_q <= '0;
					rx_sub_q <= '0;
					if (mode == DSPRT_M0) begin
						if (scon_q[SC_REN] && !scon_q[SC_RI] && !tx_m0_busy && !fifo_pop && mc_tick)
							rx_state_q <= DSPRT_RX_BITS;
					end else if (scon_q[SC_REN] && rx_prev_q && !uart_rx_in) begin
						rx_state_q <= DSPRT_RX_START;
					end
				end
				DSPRT_RX_START: begin
					if (rx_os_tick) begin
						rx_sub_q <= rx_sub_q + 4'h1;
						if (rx_sub_q == OS_MID) begin
							rx_sub_q <= '0;
							rx_state_q <= uart_rx_in ? DSPRT_RX_IDLE : DSPRT_RX_BITS;
						end
					end
				end
				DSPRT_RX_BITS: begin
					if (mode == DSPRT_M0) begin
						if (mc_tick) begin
							rx_shift_q <= {uart_rx_in, rx_shift_q[8:1]};
							rx_bit_q <= rx_bit_q + 4'h1;
							if (rx_bit_q == M0_BITS_LAST)
								rx_state_q <= DSPRT_RX_DONE;
						end
					end else if (rx_os_tick) begin
						rx_sub_q <= rx_sub_q + 4'h1;
						if (rx_sub_q == OS_LAST) begin
							rx_shift_q <= {uart_rx_in, rx_shift_q[8:1]};
							rx_bit_q <= rx_bit_q + 4'h1;
							if (rx_bit_q == RX_SAMPLES_LAST)
								rx_state_q <= DSPRT_RX_DONE;
						end
					end
				end
				DSPRT_RX_DONE: rx_state_q <= DSPRT_RX_IDLE;
				default: rx_state_q <= DSPRT_RX_IDLE;
			endcase
		end
	end

	// result lands one clock after the last sample
	assign ri_set = rx_state_q == DSPRT_RX_DONE && rx_accept;
	assign rb8_load = ri_set && mode != DSPRT_M0;
	assign rb8_val = rx_shift_q[8];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			rx_buf_q <= '0;
		else if (ri_set)
			rx_buf_q <= (mode == DSPRT_M0) ? rx_shift_q[8:1] : rx_shift_q[7:0];
	end

	// control register; hardware set wins over a firmware write
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			scon_q <= SCON_RST;
		end else begin
			if (wr_scon)
				scon_q <= sfr_wdata;
			if (ti_set)
				scon_q[SC_TI] <= 1'b1;
			if (ri_set)
				scon_q[SC_RI] <= 1'b1;
			if (rb8_load)
				scon_q[SC_RB8] <= rb8_val;
		end
	end

	// pins: mode 0 drives data on rx pin and clock on tx pin
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			tx_pin_q <= 1'b1;
		else if (mode == DSPRT_M0)
			tx_pin_q <= !((tx_m0_busy || rx_m0_busy) && mc_q < MC_HALF);
		else
			tx_pin_q <= tx_state_q == DSPRT_TX_SEND ? tx_frame_q[0] : 1'b1;
	end
	assign uart_tx = tx_pin_q;
	assign uart_rx_out = tx_frame_q[0];
	assign uart_rx_oe = tx_m0_busy;

	// register read, answered one clock after the strobe
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= '0;
		end else if (sfr_rd) begin
			if (sfr_addr == ADDR_SCON)
				rdata_q <= scon_q;
			else if (sfr_addr == ADDR_SBUF)
				rdata_q <= rx_buf_q;
			else if (sfr_addr == ADDR_RCTL)
				rdata_q <= rctl_q;
			else if (sfr_addr == ADDR_TMOD)
				rdata_q <= {5'h00, skew_q, 1'b0, dir_q};
			else if (sfr_addr == ADDR_RLO)
				rdata_q <= reload_q[7:0];
			else if (sfr_addr == ADDR_RHI)
				rdata_q <= reload_q[15:8];
			else if (sfr_addr == ADDR_CLO)
				rdata_q <= cnt_q[7:0];
			else if (sfr_addr == ADDR_CHI)
				rdata_q <= cnt_q[15:8];
			else
				rdata_q <= 8'h00;
		end
	end
	assign sfr_rdata = rdata_q;
endmodule : dsprt_top

// >>> dsprt_monitor.sv
`timescale 1ns/1ps
module dsprt_monitor
	import dsprt_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic aux_timer_ovf,
	input wire logic mode2_fast_rate,
	input wire logic uart_rx_in,
	input wire logic uart_rx_out,
	input wire logic uart_rx_oe,
	input wire logic uart_tx,
	input wire logic tx_buf_ready,
	input wire logic reload_timer_ovf
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// write of one address followed at once by its read
	sequence wr_rd(logic [7:0] a);
		sfr_wr && sfr_addr == a ##1 sfr_rd && sfr_addr == a;
	endsequence
	ovf_spacing_a: assert property (reload_timer_ovf |=> !reload_timer_ovf [*5])
		else $error("overflow pulses closer than one machine cycle");
	shift_low_a: assert property ($fell(uart_tx) && uart_rx_oe |-> !uart_tx [*3] ##1 uart_tx)
		else $error("shift clock low phase not three clocks");
	shift_high_a: assert property ($rose(uart_tx) && uart_rx_oe |-> uart_tx [*3])
		else $error("shift clock high phase too short");
	rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data changed without a read");
	reload_rb_a: assert property (wr_rd(ADDR_RLO) |=> sfr_rdata == $past(sfr_wdata, 2))
		else $error("reload byte readback differs");
	ctl_rb_a: assert property (wr_rd(ADDR_SCON) |=> sfr_rdata[7:3] == $past(sfr_wdata[7:3], 2))
		else $error("control bits readback differs");
	dir_rb_a: assert property (wr_rd(ADDR_TMOD) |=> sfr_rdata[TM_DIR] == $past(sfr_wdata[TM_DIR], 2))
		else $error("direction bit readback differs");
	ready_fall_a: assert property ($fell(tx_buf_ready) |-> $past(sfr_wr && sfr_addr == ADDR_SBUF))
		else $error("buffer full without a data write");
	cover property (reload_timer_ovf);
	cover property ($fell(uart_tx) && uart_rx_oe);
	cover property ($fell(tx_buf_ready));
endmodule : dsprt_monitor

bind dsprt_top dsprt_monitor mon (.ref_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata,
	.aux_timer_ovf, .mode2_fast_rate, .uart_rx_in, .uart_rx_out, .uart_rx_oe, .uart_tx, .tx_buf_ready,
	.reload_timer_ovf);

// >>> dsprt_term.sv
`timescale 1ns/1ps
module dsprt_term (
	input wire logic ref_clk,
	input wire logic tx_line,
	input wire logic shift_clk_oe,
	input wire logic shift_data,
	output logic rx_line
);
	int bit_clks = 16;
	int nbits = 10;
	int shift_n = 0;
	logic [10:0] word_q[$];
	logic [7:0] shift_q = 8'h00;
	logic clk_prev = 1'b1;
	initial rx_line = 1'b1;
	// start bit, then n bits lsb first, then idle high
	task automatic send(input logic [10:0] bits, input int n);
		@(negedge ref_clk);
		rx_line = 1'b0;
		repeat (bit_clks) @(negedge ref_clk);
		for (int i = 0; i < n; i++) begin
			rx_line = bits[i];
			repeat (bit_clks) @(negedge ref_clk);
		end
		rx_line = 1'b1;
	endtask : send
	always begin : async_rx
		logic [10:0] w;
		@(negedge tx_line iff !shift_clk_oe);
		w = 11'h000;
		repeat (bit_clks / 2) @(negedge ref_clk);
		for (int i = 0; i < nbits; i++) begin
			repeat (bit_clks) @(negedge ref_clk);
			w[i] = tx_line;
		end
		word_q.push_back(w);
	end
	// shift data taken at each rising shift clock
	always @(negedge ref_clk) begin
		if (shift_clk_oe && tx_line && !clk_prev) begin
			shift_q = {shift_data, shift_q[7:1]};
			shift_n++;
			if (shift_n == 8) begin
				word_q.push_back({3'h0, shift_q});
				shift_n = 0;
			end
		end
		clk_prev = tx_line;
	end
endmodule : dsprt_term

// >>> dsprt_tb_top.sv
`timescale 1ns/1ps
module dsprt_tb_top;
	import dsprt_pkg::*;
	logic ref_clk, rst_n, sfr_wr, sfr_rd, aux_timer_ovf, mode2_fast_rate, term_line;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, r;
	logic uart_rx_out, uart_rx_oe, uart_tx, tx_buf_ready, reload_timer_ovf;
	wire logic rx_pin = uart_rx_oe ? uart_rx_out : term_line;
	int n_errors = 0;
	int cmp_count = 0;
	int n;
	dsprt_top DUT (.ref_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata, .aux_timer_ovf,
		.mode2_fast_rate, .uart_rx_in(rx_pin), .uart_rx_out, .uart_rx_oe, .uart_tx, .tx_buf_ready,
		.reload_timer_ovf);
	dsprt_term term (.ref_clk, .tx_line(uart_tx), .shift_clk_oe(uart_rx_oe), .shift_data(uart_rx_out),
		.rx_line(term_line));
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	always @(negedge ref_clk) aux_timer_ovf <= rst_n ? ~aux_timer_ovf : 1'b0;
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic close_out;
		$display("mismatches %0d comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out
	task automatic fail_out;
		n_errors++;
		close_out;
	endtask : fail_out
	// strobe left up until the next access or idle
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		sfr_wr = w;
		sfr_rd = !w;
		sfr_addr = a;
		sfr_wdata = d;
	endtask : acc
	task automatic idle;
		@(negedge ref_clk);
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
	endtask : idle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		acc(1'b1, a, d);
		idle;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		acc(1'b0, a, 8'h00);
		idle;
		r = sfr_rdata;
	endtask : rd
	task automatic wait_ovf;
		int i;
		for (i = 0; i < 400 && reload_timer_ovf !== 1'b1; i++)
			@(negedge ref_clk);
		if (i == 400)
			fail_out;
	endtask : wait_ovf
	task automatic wait_frames(input int k);
		int i;
		for (i = 0; i < 40000 && term.word_q.size() < k; i++)
			@(negedge ref_clk);
		if (i == 40000)
			fail_out;
	endtask : wait_frames
	task automatic t_regs;
		logic [7:0] a[8] = '{ADDR_SCON, ADDR_RCTL, ADDR_TMOD, ADDR_RLO, ADDR_RHI, ADDR_CLO, ADDR_CHI, 8'h00};
		foreach (a[i]) begin
			rd(a[i]);
			check("reset value", r, 8'h00);
		end
		acc(1'b1, ADDR_RLO, 8'h5c);
		rd(ADDR_RLO);
		check("reload low", r, 8'h5c);
		acc(1'b1, ADDR_TMOD, 8'h05);
		rd(ADDR_TMOD);
		check("mode config", r, 8'h01);
		for (int m = 0; m < 4; m++) begin
			acc(1'b1, ADDR_SCON, {m[1:0], 6'h08});
			rd(ADDR_SCON);
			check("serial mode", r, {m[1:0], 6'h08});
		end
	endtask : t_regs
	task automatic t_timer;
		wr(ADDR_RLO, 8'h34);
		wr(ADDR_RHI, 8'h12);
		wr(ADDR_CLO, 8'hfe);
		wr(ADDR_CHI, 8'hff);
		wr(ADDR_TMOD, 8'h01);
		wr(ADDR_RCTL, 8'h04);
		wait_ovf;
		rd(ADDR_CLO);
		check("reload low copy", r, 8'h34);
		rd(ADDR_CHI);
		check("reload high copy", r, 8'h12);
		wr(ADDR_RCTL, 8'h00);
		wr(ADDR_TMOD, 8'h00);
		wr(ADDR_CLO, 8'h01);
		wr(ADDR_CHI, 8'h00);
		wr(ADDR_RCTL, 8'h04);
		wait_ovf;
		rd(ADDR_CHI);
		check("down count reload", r, 8'h12);
		wr(ADDR_RCTL, 8'h00);
		wr(ADDR_TMOD, 8'h01);
		wr(ADDR_CLO, 8'hfd);
		wr(ADDR_CHI, 8'h00);
		wr(ADDR_RCTL, 8'h04);
		rd(ADDR_CLO);
		repeat (30) @(negedge ref_clk);
		rd(ADDR_CHI);
		check("carry to high byte", r, 8'h01);
		rd(ADDR_TMOD);
		check("skew set", r[TM_SKEW], 1'b1);
		rd(ADDR_CLO);
		idle;
		rd(ADDR_TMOD);
		check("skew cleared", r[TM_SKEW], 1'b0);
		wr(ADDR_RCTL, 8'h00);
	endtask : t_timer
	task automatic t_mode1;
		term.bit_clks = 32;
		term.nbits = 9;
		term.word_q.delete();
		wr(ADDR_SCON, 8'h50);
		fork
			wr(ADDR_SBUF, 8'ha5);
			term.send({1'b1, 8'h3c}, 9);
		join
		wait_frames(1);
		check("mode1 frame", term.word_q[0], 11'h1a5);
		rd(ADDR_SCON);
		check("rx done", r[SC_RI], 1'b1);
		check("stop stored", r[SC_RB8], 1'b1);
		rd(ADDR_SBUF);
		check("rx byte", r, 8'h3c);
		term.send({1'b1, 8'hc3}, 9);
		rd(ADDR_SBUF);
		check("unread byte kept", r, 8'h3c);
	endtask : t_mode1
	task automatic t_mode2_rx;
		term.bit_clks = 16;
		wr(ADDR_SCON, 8'hb0);
		term.send({2'b10, 8'h11}, 10);
		rd(ADDR_SCON);
		check("filtered frame", r[SC_RI], 1'b0);
		term.send({2'b01, 8'h22}, 10);
		rd(ADDR_SCON);
		check("ninth bit stored", r[2:0], 3'h5);
		rd(ADDR_SBUF);
		check("mode2 rx byte", r, 8'h22);
	endtask : t_mode2_rx
	task automatic t_fifo;
		// slow mode 2 rate here, fast rate covered by the receive scenario
		mode2_fast_rate = 1'b0;
		term.bit_clks = 32;
		term.nbits = 10;
		term.word_q.delete();
		wr(ADDR_SCON, 8'h88);
		n = 0;
		while (n < 24 && tx_buf_ready === 1'b1) begin
			wr(ADDR_SBUF, 8'h30 + n[7:0]);
			n++;
		end
		wr(ADDR_SBUF, 8'hee);
		check("fifo fill", 16'(n), 16'(TX_FIFO_DEPTH + 1));
		wait_frames(n);
		repeat (200) @(negedge ref_clk);
		check("frame count", 16'(term.word_q.size()), 16'(n));
		foreach (term.word_q[i])
			check("mode2 frame", term.word_q[i], {2'b11, 8'h30 + i[7:0]});
		rd(ADDR_SCON);
		check("tx done", r[SC_TI], 1'b1);
	endtask : t_fifo
	task automatic t_mode3;
		term.bit_clks = 96;
		term.word_q.delete();
		wr(ADDR_RLO, 8'hff);
		wr(ADDR_RHI, 8'hff);
		wr(ADDR_TMOD, 8'h01);
		wr(ADDR_CLO, 8'hff);
		wr(ADDR_CHI, 8'hff);
		wr(ADDR_RCTL, 8'h14);
		wr(ADDR_SCON, 8'hc8);
		wr(ADDR_SBUF, 8'h5a);
		wait_frames(1);
		check("mode3 frame", term.word_q[0], 11'h35a);
		// let the stop bit finish before the mode changes
		repeat (100) @(negedge ref_clk);
	endtask : t_mode3
	task automatic t_mode0;
		wr(ADDR_SCON, 8'h00);
		term.word_q.delete();
		wr(ADDR_SBUF, 8'h96);
		wait_frames(1);
		check("shift byte", term.word_q[0], 11'h096);
		// mode 0 receive of a held-low line
		term.rx_line = 1'b0;
		wr(ADDR_SCON, 8'h10);
		repeat (80) @(negedge ref_clk);
		rd(ADDR_SCON);
		check("shift rx done", r[SC_RI], 1'b1);
		rd(ADDR_SBUF);
		check("shift rx byte", r, 8'h00);
	endtask : t_mode0
	initial begin
		rst_n = 1'b0;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		mode2_fast_rate = 1'b1;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		rst_n = 1'b1;
		t_regs;
		t_timer;
		t_mode1;
		t_mode2_rx;
		t_fifo;
		t_mode3;
		t_mode0;
		close_out;
	end
endmodule : dsprt_tb_top
